// *** design/meb_pkg.sv ***
// Shared constants and types of the external memory bus unit
package meb_pkg;
  // Clock and machine cycle timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int MACHINE_CYCLE_NS = 2500;
  localparam int STATES_PER_CYCLE = 5;
  localparam int CYCLE_CLKS       = MACHINE_CYCLE_NS / CLK_PERIOD_NS;
  localparam int STATE_CLKS       = CYCLE_CLKS / STATES_PER_CYCLE;
  localparam int TICK_W           = 4;
  // Program counter and internal program store
  localparam int PC_W             = 12;
  localparam int INT_ROM_WORDS    = 1024;
  // Layout of the synchroniser vector
  localparam int SYN_W            = 17;
  localparam int SYN_BUS_LSB      = 0;
  localparam int SYN_P2_LSB       = 8;
  localparam int SYN_SS           = 12;
  localparam int SYN_INT          = 13;
  localparam int SYN_TZERO        = 14;
  localparam int SYN_TONE         = 15;
  localparam int SYN_EXT          = 16;
  // Reset levels of the quasi-bidirectional lines
  localparam logic [7:0] BUS_RST  = 8'hFF;
  localparam logic [3:0] P2_RST   = 4'hF;

  // Phases of one machine cycle, plus the single step halt state
  typedef enum logic [2:0] {
    ST_S1   = 3'h0,
    ST_S2   = 3'h1,
    ST_S3   = 3'h2,
    ST_S4   = 3'h3,
    ST_S5   = 3'h4,
    ST_HALT = 3'h5
  } meb_state_type;

  // Operations the core may request
  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_FETCH   = 3'h1,
    OP_DRD     = 3'h2,
    OP_DWR     = 3'h3,
    OP_EXP_WR  = 3'h4,
    OP_EXP_RD  = 3'h5,
    OP_PORT_WR = 3'h6
  } meb_op_type;
endpackage

// *** design/meb_bus_unit.sv ***
// External program and data memory bus unit of the microcomputer
// How it works
// - External fetch drives low PC byte on bus, then reads instruction.
// - External fetch shows high PC nibble on low second-port lines.
// - Outside fetches those lines form expander bus, expander strobe.
// - Address latch strobe pulses exactly once every machine cycle.
// - Program store strobe low only during external program fetches.
// - Data access places address then data, sequenced by strobes.
// - Read strobe low during bus reads so outsiders drive data.
// - Write strobe low during bus writes to external data memory.
// - Data port can also act as statically latched output port.
// - Force external fetch input sends every fetch outside.
// - Single step input halts processor, advancing one instruction.
// - Low interrupt pin raises request only if enabled; testable.
// - Active low reset initialises all processor bus state.
// - First test input is testable and can become clock output.
// - Second test input testable and can feed event counter.
// - Every operation fits one machine cycle, one latch pulse each.
`timescale 1ns/1ps
module meb_bus_unit #(
  parameter int INT_ROM_WORDS = meb_pkg::INT_ROM_WORDS
) (
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  // Core request side
  input  wire logic                     req_valid_i,
  input  wire meb_pkg::meb_op_type      req_op_i,
  input  wire logic [meb_pkg::PC_W-1:0] req_addr_i,
  input  wire logic [7:0]               req_wdata_i,
  input  wire logic                     req_opcode_i,
  input  wire logic [7:0]               int_instr_i,
  input  wire logic [3:0]               p2_latch_i,
  output logic                          done_o,
  output logic [7:0]                    rdata_o,
  // Core control and test side
  input  wire logic                     int_enable_i,
  input  wire logic                     int_disable_i,
  input  wire logic                     enable_test_clock_out_instr_i,
  input  wire logic                     start_event_count_instr_i,
  input  wire logic                     stop_count_i,
  output logic                          irq_o,
  output logic                          int_pin_low_o,
  output logic                          test_zero_level_o,
  output logic                          test_one_level_o,
  output logic                          count_event_o,
  // Multiplexed address and data pins
  input  wire logic [7:0]               mux_addr_data_port_i,
  output logic [7:0]                    mux_addr_data_port_o,
  output logic                          mux_addr_data_port_oe_o,
  input  wire logic [3:0]               high_pc_nibble_lines_i,
  output logic [3:0]                    high_pc_nibble_lines_o,
  output logic                          high_pc_nibble_lines_oe_o,
  // Strobe pins
  output logic                          ale_o,
  output logic                          program_store_strobe_n_o,
  output logic                          rd_n_o,
  output logic                          wr_n_o,
  output logic                          expander_strobe_o,
  // Control and test pins
  input  wire logic                     force_external_fetch_i,
  input  wire logic                     single_step_n_i,
  input  wire logic                     int_n_i,
  input  wire logic                     test_input_zero_i,
  output logic                          test_input_zero_o,
  output logic                          test_input_zero_oe_o,
  input  wire logic                     test_input_one_i
);
  import meb_pkg::*;

  // Refuse timing or sizes the logic cannot serve
  if (STATE_CLKS < 2 || STATE_CLKS > 2**TICK_W) begin : g_chk_tick
    $error("STATE_CLKS does not fit the tick counter");
  end
  if (INT_ROM_WORDS < 1 || INT_ROM_WORDS >= 2**PC_W) begin : g_chk_rom
    $error("INT_ROM_WORDS out of range");
  end

  typedef struct packed {
    meb_state_type     st;
    logic [TICK_W-1:0] tick;
    meb_op_type        op;
    logic              ext;
    logic              step;
    logic [7:0]        addr;
    logic [3:0]        hi;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic [7:0]        bus_lat;
    logic              bus_static;
    logic [SYN_W-1:0]  s1;
    logic [SYN_W-1:0]  s2;
    logic              tone_prev;
    logic              int_en;
    logic              irq;
    logic              tclk_en;
    logic              tclk;
    logic              cnt_mode;
    logic              cnt_evt;
    logic              done;
    logic              ale;
    logic              program_store_strobe_n_n;
    logic              rd_n;
    logic              wr_n;
    logic              expander_strobe;
    logic [7:0]        bus_out;
    logic              bus_oe;
    logic [3:0]        p2_out;
    logic              p2_oe;
  } meb_regs_type;

  localparam meb_regs_type REGS_RST = '{
    st: ST_S5, op: OP_NONE, program_store_strobe_n_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, expander_strobe: 1'b1,
    bus_lat: BUS_RST, p2_out: P2_RST, p2_oe: 1'b1, s1: '1, s2: '1,
    tone_prev: 1'b1, default: '0};

  logic [1:0]   rst_sync_q;
  logic         rst_n;
  meb_regs_type s_q;
  meb_regs_type s_d;
  logic         last;
  logic         strobe;
  logic         ext_bus;
  logic         exp_op;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Next state of the whole unit
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    // Pin synchronisers, first stage read only by second
    s_d.s1 = {force_external_fetch_i, test_input_one_i, test_input_zero_i,
              int_n_i, single_step_n_i, high_pc_nibble_lines_i,
              mux_addr_data_port_i};
    s_d.s2 = s_q.s1;
    s_d.tone_prev = s_q.s2[SYN_TONE];
    // Interrupt enable, cleared by reset
    if (int_enable_i) begin
      s_d.int_en = 1'b1;
    end else if (int_disable_i) begin
      s_d.int_en = 1'b0;
    end
    s_d.irq = s_q.int_en & ~s_q.s2[SYN_INT];
    // Test input zero as clock output
    if (enable_test_clock_out_instr_i) begin
      s_d.tclk_en = 1'b1;
    end
    // Test input one as event counter input
    if (start_event_count_instr_i) begin
      s_d.cnt_mode = 1'b1;
    end else if (stop_count_i) begin
      s_d.cnt_mode = 1'b0;
    end
    s_d.cnt_evt = s_q.cnt_mode & s_q.tone_prev & ~s_q.s2[SYN_TONE];
    // State timing
    last = (s_q.tick == TICK_W'(STATE_CLKS - 1));
    s_d.tick = last ? '0 : s_q.tick + TICK_W'(1);
    if (last && s_q.tclk_en) begin
      s_d.tclk = ~s_q.tclk;
    end
    // Machine cycle sequence
    case (s_q.st)
      ST_S1: begin
        if (last) s_d.st = ST_S2;
      end
      ST_S2: begin
        if (last) s_d.st = ST_S3;
      end
      ST_S3: begin
        if (last) s_d.st = ST_S4;
      end
      ST_S4: begin
        if (last) begin
          s_d.st = ST_S5;
          s_d.done = (s_q.op != OP_NONE);
          case (s_q.op)
            OP_FETCH: s_d.rdata = s_q.ext ? s_q.s2[SYN_BUS_LSB +: 8]
                                          : int_instr_i;
            OP_DRD: s_d.rdata = s_q.s2[SYN_BUS_LSB +: 8];
            OP_EXP_RD: s_d.rdata = {4'h0, s_q.s2[SYN_P2_LSB +: 4]};
            default: s_d.rdata = s_q.rdata;
          endcase
        end
      end
      ST_S5: begin
        if (last) begin
          s_d.op = OP_NONE;
          if (req_valid_i && req_op_i == OP_FETCH && req_opcode_i &&
              !s_q.s2[SYN_SS] && !s_q.step) begin
            s_d.st = ST_HALT;
          end else begin
            // One operation per cycle keeps strobes apart
            s_d.st = ST_S1;
            if (req_valid_i) begin
              s_d.op = req_op_i;
            end
            s_d.addr = req_addr_i[7:0];
            s_d.hi = req_addr_i[PC_W-1:8];
            s_d.wdata = req_wdata_i;
            s_d.ext = s_q.s2[SYN_EXT] |
                      (req_addr_i >= PC_W'(INT_ROM_WORDS));
            if (req_valid_i && req_op_i == OP_FETCH && req_opcode_i) begin
              s_d.step = 1'b0;
            end
            if (req_valid_i && req_op_i == OP_PORT_WR) begin
              s_d.bus_lat = req_wdata_i;
              s_d.bus_static = 1'b1;
            end
          end
        end
      end
      ST_HALT: begin
        if (s_q.s2[SYN_SS]) begin
          s_d.st = ST_S5;
          s_d.tick = '0;
          s_d.step = 1'b1;
        end
      end
      default: s_d.st = ST_S5;
    endcase
    // Pin values for the coming state
    strobe  = (s_d.st == ST_S3) || (s_d.st == ST_S4);
    ext_bus = (s_d.op == OP_FETCH && s_d.ext) || s_d.op == OP_DRD ||
              s_d.op == OP_DWR;
    exp_op  = (s_d.op == OP_EXP_WR) || (s_d.op == OP_EXP_RD);
    s_d.ale = (s_d.st == ST_S1) || (s_d.st == ST_HALT);
    s_d.program_store_strobe_n_n = !(strobe && s_d.op == OP_FETCH && s_d.ext);
    s_d.rd_n = !(strobe && s_d.op == OP_DRD);
    s_d.wr_n = !(strobe && s_d.op == OP_DWR);
    s_d.expander_strobe = !(strobe && exp_op);
    // Data port: static latch unless a transfer owns it
    s_d.bus_out = s_d.bus_lat;
    s_d.bus_oe = s_d.bus_static;
    if (ext_bus && (s_d.st == ST_S1 || s_d.st == ST_S2)) begin
      s_d.bus_out = s_d.addr;
      s_d.bus_oe = 1'b1;
    end else if (ext_bus && strobe) begin
      s_d.bus_out = s_d.wdata;
      s_d.bus_oe = (s_d.op == OP_DWR);
    end
    // Second port lines: PC nibble, expander or port latch
    s_d.p2_out = p2_latch_i;
    s_d.p2_oe = 1'b1;
    if (s_d.op == OP_FETCH && s_d.ext && s_d.st != ST_S5) begin
      s_d.p2_out = s_d.hi;
    end else if (exp_op && (s_d.st == ST_S1 || s_d.st == ST_S2)) begin
      s_d.p2_out = s_d.addr[3:0];
    end else if (exp_op && strobe) begin
      s_d.p2_out = s_d.wdata[3:0];
      s_d.p2_oe = (s_d.op == OP_EXP_WR);
    end
  end

  // State register, initialised by reset
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= REGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign done_o                    = s_q.done;
  assign rdata_o                   = s_q.rdata;
  assign irq_o                     = s_q.irq;
  assign int_pin_low_o             = ~s_q.s2[SYN_INT];
  assign test_zero_level_o         = s_q.s2[SYN_TZERO];
  assign test_one_level_o          = s_q.s2[SYN_TONE];
  assign count_event_o             = s_q.cnt_evt;
  assign mux_addr_data_port_o      = s_q.bus_out;
  assign mux_addr_data_port_oe_o   = s_q.bus_oe;
  assign high_pc_nibble_lines_o    = s_q.p2_out;
  assign high_pc_nibble_lines_oe_o = s_q.p2_oe;
  assign ale_o                     = s_q.ale;
  assign program_store_strobe_n_o  = s_q.program_store_strobe_n_n;
  assign rd_n_o                    = s_q.rd_n;
  assign wr_n_o                    = s_q.wr_n;
  assign expander_strobe_o         = s_q.expander_strobe;
  assign test_input_zero_o         = s_q.tclk;
  assign test_input_zero_oe_o      = s_q.tclk_en;

  // Checks on the pin sequence
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n);

  a_ale_low_span: assert property (
    $fell(ale_o) |-> !ale_o [*8])
    else $error("latch strobe pulsed twice in a cycle");
  a_program_store_strobe_n_fetch_only: assert property (
    !program_store_strobe_n_o |-> s_q.op == OP_FETCH && s_q.ext)
    else $error("program store strobe outside external fetch");
  a_one_bus_owner: assert property (
    (!program_store_strobe_n_o || !rd_n_o) |->
    (program_store_strobe_n_o || rd_n_o) && !mux_addr_data_port_oe_o)
    else $error("two drivers on the data port");
  a_pc_nibble_out: assert property (
    !program_store_strobe_n_o |-> high_pc_nibble_lines_o == s_q.hi &&
    high_pc_nibble_lines_oe_o)
    else $error("high PC nibble missing during fetch");
  a_write_data: assert property (
    $fell(wr_n_o) |-> mux_addr_data_port_oe_o &&
    mux_addr_data_port_o == s_q.wdata ##8 !wr_n_o)
    else $error("write data or strobe length wrong");
  a_addr_at_latch: assert property (
    $fell(ale_o) && (s_q.op == OP_DRD || s_q.op == OP_DWR ||
    (s_q.op == OP_FETCH && s_q.ext)) |-> mux_addr_data_port_oe_o &&
    mux_addr_data_port_o == s_q.addr)
    else $error("address not held at latch strobe fall");
  a_irq_enabled: assert property (
    irq_o |-> $past(s_q.int_en) && $past(!s_q.s2[SYN_INT]))
    else $error("interrupt raised while disabled");
  a_halt_holds_ale: assert property (
    s_q.st == ST_HALT |-> ale_o && program_store_strobe_n_o)
    else $error("halt state left latch strobe low");
  a_forced_fetch: assert property (
    s_q.st == ST_S3 && s_q.op == OP_FETCH && s_q.ext |->
    !program_store_strobe_n_o)
    else $error("external fetch not strobed");
  a_done_spacing: assert property (
    done_o |=> !done_o [*8])
    else $error("two completions within one cycle");
  a_exp_strobe: assert property (
    !expander_strobe_o |-> (s_q.op == OP_EXP_WR || s_q.op == OP_EXP_RD) &&
    program_store_strobe_n_o)
    else $error("expander strobe during a fetch");
endmodule // meb_bus_unit

// *** verification/meb_mem_model.sv ***
// Partner model: external program store, data memory and expander
`timescale 1ns/1ps
module meb_mem_model #(
  parameter int LAG_CLKS = 12
) (
  // Clock of the model
  input  wire logic       clk_i,
  // Strobes from the unit
  input  wire logic       ale_i,
  input  wire logic       program_store_strobe_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       expander_strobe_i,
  // Resolved pin levels
  input  wire logic [7:0] bus_i,
  input  wire logic [3:0] nib_i,
  input  wire logic       nib_oe_i,
  // Model drive
  output logic      [7:0] bus_o,
  output logic      [3:0] nib_o,
  output logic            nib_oe_o
);
  logic [7:0]  dmem [256];
  logic [11:0] addr_q;
  logic [7:0]  last_q;
  logic [3:0]  exp_q;
  int          lag_q;
  // Known contents so reads before writes are predictable
  initial begin
    for (int i = 0; i < 256; i++) dmem[i] = ~i[7:0];
    last_q = 8'h00;
    exp_q = 4'h0;
    lag_q = 0;
  end
  // Address taken from the pins at the falling latch strobe
  always @(negedge ale_i) addr_q <= {nib_i, bus_i};
  // Writes taken while the strobes are low; lag counted
  always @(posedge clk_i) begin
    lag_q <= (program_store_strobe_n_i && rd_n_i) ? 0 : lag_q + 1;
    last_q <= bus_o;
    if (!wr_n_i) dmem[addr_q[7:0]] <= bus_i;
    if (!expander_strobe_i && nib_oe_i) exp_q <= nib_i;
  end
  // Slow answer; outside it a pattern that flips every clock
  always_comb begin
    bus_o = ~last_q;
    if (!program_store_strobe_n_i && lag_q >= LAG_CLKS)
      bus_o = addr_q[7:0] ^ {addr_q[11:8], 4'h3};
    else if (!rd_n_i && lag_q >= LAG_CLKS)
      bus_o = dmem[addr_q[7:0]];
    nib_oe_o = !expander_strobe_i && !nib_oe_i;
    nib_o = exp_q;
  end
endmodule // meb_mem_model

// *** verification/meb_bus_unit_tb.sv ***
// Self-checking bench of the external memory bus unit
`timescale 1ns/1ps
module meb_bus_unit_tb;
  import meb_pkg::*;
  logic        core_clk_i = 1'b0, rstn_i = 1'b0, req_valid_i = 1'b0;
  meb_op_type  req_op_i = OP_NONE;
  logic [11:0] req_addr_i = 12'h000;
  logic [7:0]  req_wdata_i = 8'h00, int_instr_i = 8'h00;
  logic [3:0]  p2_latch_i = 4'hA;
  logic        int_enable_i = 1'b0, int_disable_i = 1'b0, t0_pin = 1'b1;
  logic        enable_test_clock_out_instr_i = 1'b0, int_n_i = 1'b1;
  logic        start_event_count_instr_i = 1'b0, test_input_one_i = 1'b1;
  logic        force_external_fetch_i = 1'b0, ale_prev = 1'b0;
  logic        ss_n = 1'b1, opc = 1'b0;
  logic        done_o, irq_o, int_pin_low_o, test_zero_level_o, ale_o;
  logic        test_one_level_o, count_event_o, program_store_strobe_n_o;
  logic        rd_n_o, wr_n_o, expander_strobe_o, test_input_zero_o, nib_oe;
  logic        test_input_zero_oe_o, mux_addr_data_port_oe_o, started = 0;
  logic        high_pc_nibble_lines_oe_o;
  logic [7:0]  rdata_o, mux_addr_data_port_o, m_bus;
  logic [3:0]  high_pc_nibble_lines_o, m_nib;
  logic [2:0]  seen = 3'h0;
  logic [11:0] notes [$];
  int          error_cnt = 0, n_checks = 0, ale_cnt = 0, cc = 0, ev;
  int          seed = 32'hB8B5;
  wire  [7:0]  mux_addr_data_port_i =
    mux_addr_data_port_oe_o ? mux_addr_data_port_o : m_bus;
  wire  [3:0]  high_pc_nibble_lines_i = high_pc_nibble_lines_oe_o ?
    high_pc_nibble_lines_o : (nib_oe ? m_nib : 4'hF);
  wire         test_input_zero_i =
    test_input_zero_oe_o ? test_input_zero_o : t0_pin;

  meb_bus_unit meb_bus_unit_inst (
    .core_clk_i, .rstn_i, .req_valid_i, .req_op_i, .req_addr_i,
    .req_wdata_i, .req_opcode_i(opc), .int_instr_i, .p2_latch_i, .done_o,
    .rdata_o, .int_enable_i, .int_disable_i, .enable_test_clock_out_instr_i,
    .start_event_count_instr_i, .stop_count_i(1'b0), .irq_o, .int_pin_low_o,
    .test_zero_level_o, .test_one_level_o, .count_event_o,
    .mux_addr_data_port_i, .mux_addr_data_port_o, .mux_addr_data_port_oe_o,
    .high_pc_nibble_lines_i, .high_pc_nibble_lines_o,
    .high_pc_nibble_lines_oe_o, .ale_o, .program_store_strobe_n_o, .rd_n_o,
    .wr_n_o, .expander_strobe_o, .force_external_fetch_i,
    .single_step_n_i(ss_n), .int_n_i, .test_input_zero_i, .test_input_zero_o,
    .test_input_zero_oe_o, .test_input_one_i);

  meb_mem_model meb_mem_model_inst (
    .clk_i(core_clk_i), .ale_i(ale_o),
    .program_store_strobe_n_i(program_store_strobe_n_o), .rd_n_i(rd_n_o),
    .wr_n_i(wr_n_o), .expander_strobe_i(expander_strobe_o),
    .bus_i(mux_addr_data_port_i), .nib_i(high_pc_nibble_lines_i),
    .nib_oe_i(high_pc_nibble_lines_oe_o), .bus_o(m_bus), .nib_o(m_nib),
    .nib_oe_o(nib_oe));

  // Clock of 50 ns
  always #25 core_clk_i = ~core_clk_i;

  // Compare, count and report
  task automatic check(logic [11:0] s, logic [11:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Counts and verdict, then end of run
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Wait clock edges, then step just past the edge
  task automatic tick(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Expected program store byte of the model
  function automatic logic [7:0] rom(logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'h3};
  endfunction

  // One request held until done; note = {read, program_store_strobe_n, rd, wr, byte}
  task automatic op(meb_op_type o, logic [11:0] a, logic [7:0] w,
                    logic [11:0] e);
    int n;
    notes.push_back(e);
    req_op_i = o;
    req_addr_i = a;
    req_wdata_i = w;
    req_valid_i = 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 200);
    if (done_o !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  // Strobes seen per operation against the oldest note, mid-cycle
  always @(negedge core_clk_i) begin
    logic [11:0] e;
    seen |= {~program_store_strobe_n_o, ~rd_n_o, ~wr_n_o};
    if (ale_o && !ale_prev) ale_cnt++;
    ale_prev = ale_o;
    cc++;
    if (done_o === 1'b1) begin
      e = notes.size() > 0 ? notes.pop_front() : 12'hFFF;
      check({9'h0, seen}, {9'h0, e[10:8]});
      if (e[11]) check({4'h0, rdata_o}, {4'h0, e[7:0]});
      if (started) check(12'(ale_cnt), 12'(cc / 50));
      started = 1'b1;
      seen = 3'h0;
      ale_cnt = 0;
      cc = 0;
    end
  end

  // Main sequence
  initial begin
    logic [11:0] a;
    logic [7:0]  w;
    logic [7:0]  sh [256];
    for (int i = 0; i < 256; i++) sh[i] = ~i[7:0];
    tick(6);
    rstn_i = 1'b1;
    check({11'h0, irq_o}, 12'h000);
    for (int i = 0; i < 4; i++) begin
      a = 12'($random(seed)) | 12'hC00;
      op(OP_FETCH, a, 8'h00, {4'hC, rom(a)});
    end
    a = 12'($random(seed)) & 12'h3FF;
    int_instr_i = 8'($random(seed));
    op(OP_FETCH, a, 8'h00, {4'h8, int_instr_i});
    force_external_fetch_i = 1'b1;
    op(OP_FETCH, a, 8'h00, {4'hC, rom(a)});
    force_external_fetch_i = 1'b0;
    // Single step: opcode fetch halts, one high pulse lets it run
    a = 12'($random(seed)) | 12'hC00;
    ss_n = 1'b0;
    opc = 1'b1;
    fork
      op(OP_FETCH, a, 8'h00, {4'hC, rom(a)});
      begin
        tick(60);
        check({11'h0, ale_o}, 12'h001);
        ss_n = 1'b1;
        tick(3);
        ss_n = 1'b0;
      end
    join
    opc = 1'b0;
    ss_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      a = {4'h0, 8'($random(seed))};
      w = 8'($random(seed));
      op(OP_DRD, a, 8'h00, {4'hA, sh[a[7:0]]});
      op(OP_DWR, a, w, 12'h100);
      sh[a[7:0]] = w;
      op(OP_DRD, a, 8'h00, {4'hA, w});
    end
    op(OP_EXP_WR, 12'h004, w, 12'h000);
    op(OP_EXP_RD, 12'h000, 8'h00, {8'h80, w[3:0]});
    op(OP_PORT_WR, 12'h000, w, 12'h000);
    req_valid_i = 1'b0;
    tick(2);
    check({3'h0, mux_addr_data_port_oe_o, mux_addr_data_port_o}, {4'h1, w});
    int_n_i = 1'b0;
    tick(5);
    check({10'h0, int_pin_low_o, irq_o}, 12'h002);
    int_enable_i = 1'b1;
    tick(1);
    int_enable_i = 1'b0;
    tick(3);
    check({11'h0, irq_o}, 12'h001);
    int_disable_i = 1'b1;
    tick(1);
    int_disable_i = 1'b0;
    t0_pin = 1'b0;
    test_input_one_i = 1'b0;
    tick(4);
    check({9'h0, irq_o, test_zero_level_o, test_one_level_o}, 12'h000);
    start_event_count_instr_i = 1'b1;
    test_input_one_i = 1'b1;
    tick(1);
    start_event_count_instr_i = 1'b0;
    tick(4);
    test_input_one_i = 1'b0;
    ev = 0;
    repeat (8) begin
      tick(1);
      ev += (count_event_o === 1'b1);
    end
    check(12'(ev), 12'h001);
    enable_test_clock_out_instr_i = 1'b1;
    tick(1);
    enable_test_clock_out_instr_i = 1'b0;
    tick(4);
    w[0] = test_input_zero_o;
    tick(10);
    check({10'h0, test_input_zero_oe_o, test_input_zero_o}, {10'h0, 1'b1, ~w[0]});
    print_verdict();
  end

  // Watchdog against a hang
  initial begin
    #2000000;
    error_cnt++;
    print_verdict();
  end
endmodule // meb_bus_unit_tb
